// ==== rtl/flash_bus_host.sv ====
// Purpose: Host controller driving the x8 flash bus strobes
// Assumes: Inputs synchronous to clk; flash needs no clock of its own
// Notes:   One request per bus cycle; read bytes pass through a FIFO
//
// Behaviour
// - Read cycles: chip select low, latches low
// - Each read strobe fall yields one byte
// - Guard high for program, erase, data
// - Address takes five bytes, padded fields
// - Read: 00h, address, 30h
// - Program 80h..10h, erase 60h..D0h
// - Address and data between the two codes
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host
	import flash_host_pkg::*;
(
	input  wire logic        clk,          // 250 MHz clock
	input  wire logic        nrst,         // Async reset, low
	input  wire logic        req_valid,    // Request present
	input  wire logic [2:0]  req_op,       // Request opcode
	input  wire logic [7:0]  req_byte,     // Command or data byte
	input  wire logic [29:0] req_addr,     // Full flash address
	output logic             req_ready_ff, // Request accepted, pulse
	output logic             req_err_ff,   // Request refused, pulse
	output logic [7:0]       rd_data,      // Read byte from FIFO
	output logic             rd_valid,     // Read byte valid
	input  wire logic        rd_ready,     // Read byte taken
	input  wire logic        guard_en,     // Allow program/erase
	output logic             chip_sel_n_ff,// Chip select, low active
	output logic             cmd_latch_en_ff, // Command latch enable
	output logic             addr_latch_en_ff,// Address latch enable
	output logic             wr_strobe_n_ff,  // Write strobe, low active
	output logic             rd_strobe_n_ff,  // Read strobe, low active
	output logic             write_guard_n_ff,// Write guard, low protects
	output logic [7:0]       data_bus_o_ff,   // Data bus out
	output logic             data_bus_oe_ff,  // Data bus output enable
	input  wire logic [7:0]  data_bus_i,      // Data bus in
	input  wire logic        ready_busy_n,    // Flash ready, high
	output logic             busy_ff          // Flash busy seen
);
	// ==========================================
	// State machine
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_WLOW  = 3'b010,
		ST_WHIGH = 3'b011,
		ST_RLOW  = 3'b100,
		ST_RHIGH = 3'b101
	} state_type;
	state_type   state_ff, nxt_state;   // Bus cycle state
	logic [3:0]  tmr_ff;                // Phase timer
	logic [2:0]  acnt_ff;               // Address byte index
	logic [2:0]  op_ff;                 // Op in progress
	logic [7:0]  pend_ff;               // Pending setup code
	logic        cache_ff;              // Cache read in progress
	logic        fifo_in_ready;         // FIFO has room
	logic        fifo_push_ff;          // Capture pulse
	logic [7:0]  fifo_byte_ff;          // Captured byte

	// Address byte for cycle n, with zero padding
	function automatic logic [7:0] addr_byte(input logic [29:0] a, input logic [2:0] n);
		case (n)
			3'h0:    addr_byte = a[7:0];
			3'h1:    addr_byte = {4'h0, a[11:8]};
			3'h2:    addr_byte = a[19:12];
			3'h3:    addr_byte = a[27:20];
			3'h4:    addr_byte = {6'h00, a[29:28]};
			default: addr_byte = 8'h00;
		endcase
	endfunction

	// Code classes
	wire is_pe_code = (req_byte == CMD_PROG) || (req_byte == CMD_ERASE) ||
		(req_byte == CMD_PROG_CF) || (req_byte == CMD_ERASE_CF) ||
		(req_byte == CMD_RND_IN);
	wire busy_ok = (req_byte == CMD_RESET) || (req_byte == CMD_STATUS) ||
		(cache_ff && req_byte == CMD_EXIT_CACHE);
	wire cf_ok = (req_byte == CMD_READ_CONF || req_byte == CMD_CACHE_CF) ?
		(pend_ff == CMD_READ || pend_ff == 8'hFE) :
		(req_byte == CMD_PROG_CF)    ? (pend_ff == CMD_PROG) :
		(req_byte == CMD_ERASE_CF)   ? (pend_ff == CMD_ERASE) :
		(req_byte == CMD_RND_OUT_CF) ? (pend_ff == CMD_RND_OUT) : 1'b1;
	wire is_busy  = !ready_busy_n;
	wire guard_bad = is_pe_code && !guard_en;
	wire cmd_bad  = (req_op == OP_CMD) &&
		((is_busy && !busy_ok) || guard_bad || !cf_ok);
	wire wd_bad   = (req_op == OP_WDATA) && (is_busy || !guard_en);
	wire rd_bad   = (req_op == OP_RDATA) && (is_busy || !fifo_in_ready);
	wire adr_bad  = (req_op == OP_ADDR) && (is_busy || acnt_ff >= ADDR_CYCLES);
	wire bad_op   = req_op > OP_IDLE;
	wire refuse   = cmd_bad || wd_bad || rd_bad || adr_bad || bad_op;
	wire start    = (state_ff == ST_IDLE) && req_valid && !req_ready_ff && !req_err_ff;
	wire tmr_done = tmr_ff == 4'h0;
	wire write_op = (op_ff == OP_CMD) || (op_ff == OP_ADDR) || (op_ff == OP_WDATA);

	// Next state decode
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:  if (start && !refuse && req_op != OP_IDLE) nxt_state = ST_SETUP;
			ST_SETUP: if (tmr_done) nxt_state = write_op ? ST_WLOW : ST_RLOW;
			ST_WLOW:  if (tmr_done) nxt_state = ST_WHIGH;
			ST_WHIGH: if (tmr_done) nxt_state = ST_IDLE;
			ST_RLOW:  if (tmr_done) nxt_state = ST_RHIGH;
			ST_RHIGH: if (tmr_done) nxt_state = ST_IDLE;
			default:  nxt_state = ST_IDLE;
		endcase
	end

	// State and timer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			tmr_ff   <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			tmr_ff   <= (nxt_state != state_ff) ? STROBE_CYC - 4'h1 :
				(tmr_done ? 4'h0 : tmr_ff - 4'h1);
		end
	end

	// Request answer pulses
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			req_ready_ff <= 1'b0;
			req_err_ff   <= 1'b0;
		end else begin
			req_err_ff   <= start && refuse;
			req_ready_ff <= (start && !refuse && req_op == OP_IDLE) ||
				((state_ff == ST_WHIGH || state_ff == ST_RHIGH) && tmr_done);
		end
	end

	// Latch op and command tracking
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			op_ff    <= OP_IDLE;
			acnt_ff  <= 3'h0;
			pend_ff  <= 8'hFE;
			cache_ff <= 1'b0;
		end else if (start && !refuse) begin
			op_ff <= req_op;
			if (req_op == OP_CMD) begin
				acnt_ff <= 3'h0;
				// Setup codes wait for their confirm; read confirm sets FEh, others except random input clear it
				if (req_byte == CMD_READ || req_byte == CMD_PROG ||
					req_byte == CMD_ERASE || req_byte == CMD_RND_OUT)
					pend_ff <= req_byte;
				else if (req_byte != CMD_RND_IN) // Random input keeps program pending
					pend_ff <= (req_byte == CMD_READ_CONF) ? 8'hFE : 8'h00;
				if (req_byte == CMD_CACHE_CF) cache_ff <= 1'b1;
				else if (req_byte == CMD_EXIT_CACHE || req_byte == CMD_RESET)
					cache_ff <= 1'b0;
			end else if (req_op == OP_ADDR) begin
				acnt_ff <= acnt_ff + 3'h1;
			end
		end
	end

	// Pin drivers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chip_sel_n_ff    <= 1'b1;
			cmd_latch_en_ff  <= 1'b0;
			addr_latch_en_ff <= 1'b0;
			wr_strobe_n_ff   <= 1'b1;
			rd_strobe_n_ff   <= 1'b1;
			data_bus_o_ff    <= 8'h00;
			data_bus_oe_ff   <= 1'b0;
		end else if (start && !refuse && req_op != OP_IDLE) begin
			chip_sel_n_ff    <= 1'b0;
			cmd_latch_en_ff  <= req_op == OP_CMD;
			addr_latch_en_ff <= req_op == OP_ADDR;
			data_bus_oe_ff   <= req_op != OP_RDATA;
			data_bus_o_ff    <= (req_op == OP_ADDR) ? addr_byte(req_addr, acnt_ff) : req_byte;
		end else if (start && req_op == OP_IDLE) begin
			chip_sel_n_ff    <= 1'b1;
			data_bus_oe_ff   <= 1'b0;
		end else begin
			wr_strobe_n_ff <= !(nxt_state == ST_WLOW);
			rd_strobe_n_ff <= !(nxt_state == ST_RLOW);
			if (nxt_state == ST_IDLE) begin
				cmd_latch_en_ff  <= 1'b0;
				addr_latch_en_ff <= 1'b0;
				data_bus_oe_ff   <= 1'b0;
			end
		end
	end

	// Live guard follows the enable every cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			write_guard_n_ff <= 1'b0;
			busy_ff          <= 1'b0;
		end else begin
			write_guard_n_ff <= guard_en;
			busy_ff          <= is_busy;
		end
	end

	// Read byte capture at end of the low phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fifo_push_ff <= 1'b0;
			fifo_byte_ff <= 8'h00;
		end else begin
			fifo_push_ff <= (state_ff == ST_RLOW) && tmr_done;
			fifo_byte_ff <= data_bus_i;
		end
	end

	byte_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.in_data   (fifo_byte_ff),
		.in_valid  (fifo_push_ff),
		.in_ready  (fifo_in_ready),
		.out_data  (rd_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready)
	);

	// ==========================================
	// Assertions
	a_read_no_drive: assert property (@(posedge clk) disable iff (!nrst)
		!rd_strobe_n_ff |-> !data_bus_oe_ff && !cmd_latch_en_ff && !addr_latch_en_ff)
		else $error("Bus driven during read strobe");
	a_strobe_excl: assert property (@(posedge clk) disable iff (!nrst)
		!(!rd_strobe_n_ff && !wr_strobe_n_ff))
		else $error("Both strobes low");
	a_cmd_levels: assert property (@(posedge clk) disable iff (!nrst)
		$rose(wr_strobe_n_ff) && cmd_latch_en_ff |->
			!chip_sel_n_ff && !addr_latch_en_ff && rd_strobe_n_ff)
		else $error("Command strobe with wrong levels");
	a_addr_levels: assert property (@(posedge clk) disable iff (!nrst)
		$rose(wr_strobe_n_ff) && addr_latch_en_ff |-> !chip_sel_n_ff && !cmd_latch_en_ff)
		else $error("Address strobe with wrong levels");
	a_guard_live: assert property (@(posedge clk) disable iff (!nrst)
		##1 write_guard_n_ff == $past(guard_en))
		else $error("Guard output not following enable");
	a_guard_pe: assert property (@(posedge clk) disable iff (!nrst)
		start && req_op == OP_CMD && req_byte == CMD_PROG && !guard_en |=> req_err_ff)
		else $error("Program issued under guard");
	a_busy_refuse: assert property (@(posedge clk) disable iff (!nrst)
		start && is_busy && req_op == OP_CMD && req_byte == CMD_SIG |=> req_err_ff)
		else $error("Command issued while busy");
	a_addr_limit: assert property (@(posedge clk) disable iff (!nrst)
		start && req_op == OP_ADDR && acnt_ff == ADDR_CYCLES |=> req_err_ff)
		else $error("Sixth address byte sent");
	a_wr_pulse_len: assert property (@(posedge clk) disable iff (!nrst)
		$fell(wr_strobe_n_ff) |-> !wr_strobe_n_ff [*6])
		else $error("Write strobe too short");
	c_cmd: cover property (@(posedge clk) $rose(wr_strobe_n_ff) && cmd_latch_en_ff);
	c_read: cover property (@(posedge clk) fifo_push_ff);
	c_refuse: cover property (@(posedge clk) req_err_ff);
	c_fifo_full: cover property (@(posedge clk) !fifo_in_ready);
endmodule
`default_nettype wire

// ==== rtl/flash_host_pkg.sv ====
// Purpose: Constants for the parallel flash host controller
// Assumes: 250 MHz clock, x8 multiplexed flash bus
// Notes:   Command codes, address layout and strobe timing counts
package flash_host_pkg;
	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_READ      = 8'h00;
	localparam logic [7:0] CMD_READ_CONF = 8'h30;
	localparam logic [7:0] CMD_CACHE_CF  = 8'h31;
	localparam logic [7:0] CMD_EXIT_CACHE = 8'h34;
	localparam logic [7:0] CMD_RND_OUT   = 8'h05;
	localparam logic [7:0] CMD_RND_OUT_CF = 8'hE0;
	localparam logic [7:0] CMD_PROG      = 8'h80;
	localparam logic [7:0] CMD_PROG_CF   = 8'h10;
	localparam logic [7:0] CMD_RND_IN    = 8'h85;
	localparam logic [7:0] CMD_ERASE     = 8'h60;
	localparam logic [7:0] CMD_ERASE_CF  = 8'hD0;
	localparam logic [7:0] CMD_RESET     = 8'hFF;
	localparam logic [7:0] CMD_SIG       = 8'h90;
	localparam logic [7:0] CMD_STATUS    = 8'h70;
	// ==========================================
	// Address layout
	localparam int ADDR_W    = 30;
	localparam int COL_LSB   = 0;
	localparam int COL_W     = 12;
	localparam int PAGE_LSB  = 12;
	localparam int PAGE_W    = 7;
	localparam int BLOCK_LSB = 19;
	localparam int BLOCK_W   = 11;
	localparam logic [2:0] ADDR_CYCLES = 3'h5;
	// ==========================================
	// Strobe timing: each strobe phase lasts at least this long
	localparam int CLK_PERIOD_PS = 4000;
	localparam int STROBE_PS     = 24000;
	localparam logic [3:0] STROBE_CYC =
		4'((STROBE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// ==========================================
	// Host request opcodes
	localparam logic [2:0] OP_CMD   = 3'h0;
	localparam logic [2:0] OP_ADDR  = 3'h1;
	localparam logic [2:0] OP_WDATA = 3'h2;
	localparam logic [2:0] OP_RDATA = 3'h3;
	localparam logic [2:0] OP_IDLE  = 3'h4;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 4;
endpackage

// ==== rtl/byte_fifo.sv ====
// Purpose: Small valid/ready FIFO for the read data path
// Assumes: Single clock
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk,     // Clock
	input  wire logic         nrst,    // Async reset, low
	input  wire logic [W-1:0] in_data, // Write data
	input  wire logic         in_valid,// Write valid
	output logic              in_ready,// Not full
	output logic [W-1:0]      out_data,// Head word
	output logic              out_valid,// Not empty
	input  wire logic         out_ready // Drain
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem_ff [D];  // Storage
	logic [AW:0]   wr_ff;       // Write pointer with wrap bit
	logic [AW:0]   rd_ff;       // Read pointer with wrap bit
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;
	assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(D);
	assign out_valid = wr_ff != rd_ff;
	assign out_data  = mem_ff[rd_ff[AW-1:0]];
	// Pointer update
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (do_wr) wr_ff <= wr_ff + 1'b1;
			if (do_rd) rd_ff <= rd_ff + 1'b1;
		end
	end
	// Storage write
	always_ff @(posedge clk) begin
		if (do_wr) mem_ff[wr_ff[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
// Purpose: Behavioural flash device answering the host strobes
// Assumes: Busy time in ns; an array byte is a function of its column
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
	parameter int         BUSY_NS = 200,   // Busy time after a confirm
	parameter logic [7:0] SIG_ID  = 8'h96, // Signature, arbitrary value
	parameter logic [7:0] STAT    = 8'hC1  // Status byte shown
) (
	input  wire logic        cs_n,   // Chip select, low active
	input  wire logic        cle,    // Command latch enable
	input  wire logic        ale,    // Address latch enable
	input  wire logic        we_n,   // Write strobe
	input  wire logic        re_n,   // Read strobe
	input  wire logic        wp_n,   // Write guard, low protects
	input  wire logic [7:0]  dq,     // Bus as the device sees it
	output logic      [7:0]  dq_o,   // Device side of the bus
	output logic             rb_n,   // Ready/busy
	output logic      [7:0]  cmd_q,  // Last code taken
	output logic      [39:0] adr_q,  // Address bytes taken
	output logic      [7:0]  dat_q,  // Last program byte
	output logic             prog_q  // A program was started
);
	logic [11:0] col;   // Column counter
	logic [7:0]  last;  // Last byte put out
	logic [1:0]  src;   // Source: 0 array, 1 status, 2 signature
	logic [2:0]  n_adr; // Address bytes so far
	logic        cache; // Cache read running
	logic        sel;   // Output cycle levels present
	assign sel  = !cs_n && we_n && !ale && !cle;
	assign dq_o = sel ? last : ~last;
	initial begin
		{rb_n, cmd_q, adr_q, dat_q, prog_q} = {1'b1, 57'h0};
		{col, last, src, n_adr, cache} = 26'h0;
	end
	// ==========================================
	// Write strobe rise: command, address or data
	always @(posedge we_n) begin
		if (!cs_n && re_n && cle && !ale) begin
			// Busy: only reset, status, exit cache
			if (rb_n || dq == 8'hFF || dq == 8'h70 || (dq == 8'h34 && cache)) begin
				cmd_q <= dq;
				n_adr <= 3'h0;
				src   <= (dq == 8'h70) ? 2'h1 : (dq == 8'h90) ? 2'h2 : 2'h0;
				if (dq == 8'h31 || dq == 8'h34)
					cache <= (dq == 8'h31);
				// Only a confirm starts work; guard read live
				if (dq == 8'h30 || dq == 8'h31 || (wp_n && (dq == 8'h10 || dq == 8'hD0))) begin
					rb_n <= 1'b0;
					rb_n <= #(BUSY_NS) 1'b1;
				end
				if (wp_n && dq == 8'h10)
					prog_q <= 1'b1;
			end
		end else if (!cs_n && re_n && ale && !cle && n_adr < 3'h5) begin
			adr_q[8*n_adr +: 8] <= dq;
			n_adr <= n_adr + 3'h1;
			if (n_adr == 3'h0)
				col[7:0] <= dq;
			if (n_adr == 3'h1)
				col[11:8] <= dq[3:0];
		end else if (!cs_n && re_n && !ale && !cle && wp_n) begin
			dat_q <= dq;
		end
	end
	// ==========================================
	// Read strobe fall: next byte, column steps on array reads
	always @(negedge re_n) begin
		if (sel) begin
			last <= (src == 2'h1) ? STAT : (src == 2'h2) ? SIG_ID : col[7:0] ^ 8'h3C;
			if (src == 2'h0)
				col <= col + 12'h001;
		end
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the flash bus host
// Assumes: Device model on the far side of the pins
// Notes:   Inputs change on the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module testbench
	import flash_host_pkg::*;
;
	localparam logic [7:0] SIG = 8'h96; // Signature, arbitrary value
	localparam logic [7:0] ST  = 8'hC1; // Status byte of the model
	logic        clk, nrst, req_valid, rd_ready, guard_en, busy_ff, ready_busy_n;
	logic        req_ready_ff, req_err_ff, rd_valid, prog_q, data_bus_oe_ff;
	logic        chip_sel_n_ff, cmd_latch_en_ff, addr_latch_en_ff, wr_strobe_n_ff;
	logic        rd_strobe_n_ff, write_guard_n_ff;
	logic [2:0]  req_op;
	logic [29:0] req_addr;
	logic [39:0] adr_q;
	logic [7:0]  req_byte, rd_data, data_bus_o_ff, dev_dq, bus, cmd_q, dat_q;
	int          err_count = 0;
	int          compares  = 0;
	assign bus = data_bus_oe_ff ? data_bus_o_ff : dev_dq; // Wire level
	flash_bus_host u_dut (.clk, .nrst, .req_valid, .req_op, .req_byte, .req_addr,
		.req_ready_ff, .req_err_ff, .rd_data, .rd_valid, .rd_ready, .guard_en,
		.chip_sel_n_ff, .cmd_latch_en_ff, .addr_latch_en_ff, .wr_strobe_n_ff,
		.rd_strobe_n_ff, .write_guard_n_ff, .data_bus_o_ff, .data_bus_oe_ff,
		.data_bus_i(bus), .ready_busy_n, .busy_ff);
	flash_dev_model #(.BUSY_NS(200), .SIG_ID(SIG), .STAT(ST)) u_dev (.cs_n(chip_sel_n_ff),
		.cle(cmd_latch_en_ff), .ale(addr_latch_en_ff), .we_n(wr_strobe_n_ff),
		.re_n(rd_strobe_n_ff), .wp_n(write_guard_n_ff), .dq(bus), .dq_o(dev_dq),
		.rb_n(ready_busy_n), .cmd_q, .adr_q, .dat_q, .prog_q);
	always #2 clk = ~clk; // 250 MHz
	// ==========================================
	// Shared tasks
	task automatic test_done();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic bound(int i, int lim); // A wait ran out
		if (i >= lim) begin
			err_count++;
			test_done();
		end
	endtask
	// One request, held until answered; e is the expected refusal
	task automatic cmd(logic [2:0] op, logic [7:0] b, logic e);
		int i;
		@(negedge clk);
		req_valid = 1'b1;
		req_op    = op;
		req_byte  = b;
		for (i = 0; i < 200; i++) begin
			@(negedge clk);
			if (req_ready_ff === 1'b1 || req_err_ff === 1'b1)
				break;
		end
		req_valid = 1'b0;
		bound(i, 200);
		check("refused", req_err_ff, e);
	endtask
	task automatic addr(logic [29:0] a); // Five bytes, then one too many
		req_addr = a;
		repeat (5) cmd(OP_ADDR, 8'h00, 1'b0);
		check("addr", adr_q, {6'h00, a[29:20], a[19:12], 4'h0, a[11:0]});
		cmd(OP_ADDR, 8'h00, 1'b1);
	endtask
	task automatic wait_ready();
		int i;
		for (i = 0; i < 500 && (ready_busy_n !== 1'b1 || busy_ff !== 1'b0); i++)
			@(negedge clk);
		bound(i, 500);
	endtask
	task automatic pop(logic [7:0] exp); // Take the FIFO head
		int i;
		for (i = 0; i < 100 && rd_valid !== 1'b1; i++)
			@(negedge clk);
		bound(i, 100);
		check("byte", rd_data, exp);
		rd_ready = 1'b1;
		@(negedge clk);
		rd_ready = 1'b0;
	endtask
	// ==========================================
	// Scenarios
	task automatic s_read(); // Page read, FIFO filled to refusal
		cmd(OP_CMD, CMD_READ, 1'b0);
		addr(30'h2ABC_D123);
		cmd(OP_CMD, CMD_READ_CONF, 1'b0);
		check("code", cmd_q, CMD_READ_CONF);
		wait_ready();
		for (int k = 0; k < 4; k++) cmd(OP_RDATA, 8'h00, 1'b0);
		cmd(OP_RDATA, 8'h00, 1'b1);
		for (int k = 0; k < 4; k++) pop(8'(8'h23 + k) ^ 8'h3C);
		check("drained", rd_valid, 1'b0);
		cmd(OP_CMD, CMD_READ_CONF, 1'b0);
		wait_ready();
	endtask
	task automatic s_prog(); // Guard refusal, then full program
		cmd(OP_CMD, CMD_PROG, 1'b1);
		check("guard pin", write_guard_n_ff, 1'b0);
		guard_en = 1'b1;
		cmd(OP_CMD, CMD_PROG, 1'b0);
		addr(30'h0004_5008);
		cmd(OP_WDATA, 8'h5A, 1'b0);
		check("prog data", dat_q, 8'h5A);
		cmd(OP_CMD, CMD_RND_IN, 1'b0);
		repeat (2) cmd(OP_ADDR, 8'h00, 1'b0);
		check("code", cmd_q, CMD_RND_IN);
		guard_en = 1'b0;
		cmd(OP_WDATA, 8'hA5, 1'b1);
		guard_en = 1'b1;
		cmd(OP_CMD, CMD_PROG_CF, 1'b0);
		check("started", prog_q, 1'b1);
		wait_ready();
	endtask
	task automatic s_erase(); // Wrong confirm, busy refusals
		cmd(OP_CMD, CMD_ERASE, 1'b0);
		addr(30'h1F80_0000);
		cmd(OP_CMD, CMD_READ_CONF, 1'b1);
		cmd(OP_CMD, CMD_ERASE_CF, 1'b0);
		check("busy", busy_ff, 1'b1);
		cmd(OP_CMD, CMD_READ, 1'b1);
		cmd(OP_CMD, CMD_SIG, 1'b1);
		cmd(OP_CMD, CMD_STATUS, 1'b0);
		wait_ready();
		cmd(OP_RDATA, 8'h00, 1'b0);
		pop(ST);
	endtask
	task automatic s_codes(); // Signature, random out, cache, idle
		cmd(OP_CMD, CMD_SIG, 1'b0);
		cmd(OP_RDATA, 8'h00, 1'b0);
		pop(SIG);
		cmd(OP_CMD, CMD_RND_OUT, 1'b0);
		cmd(OP_CMD, CMD_RND_OUT_CF, 1'b0);
		cmd(OP_CMD, CMD_READ, 1'b0);
		addr(30'h0000_0000);
		cmd(OP_CMD, CMD_CACHE_CF, 1'b0);
		cmd(OP_CMD, CMD_EXIT_CACHE, 1'b0);
		wait_ready();
		cmd(OP_CMD, 8'hAB, 1'b0);
		cmd(OP_CMD, CMD_RESET, 1'b0);
		cmd(3'h5, 8'h00, 1'b1);
		cmd(OP_IDLE, 8'h00, 1'b0);
		check("standby", {chip_sel_n_ff, data_bus_oe_ff}, 2'h2);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{clk, nrst, req_valid, rd_ready, guard_en} = 5'h00;
		{req_op, req_byte, req_addr} = {OP_IDLE, 38'h0};
		repeat (10) @(negedge clk);
		check("guard reset", write_guard_n_ff, 1'b0);
		nrst = 1'b1;
		s_read();
		s_prog();
		s_erase();
		s_codes();
		test_done();
	end
endmodule
`default_nettype wire
